// File: spi_pkg.sv
/*
 spi_pkg: offsets, field positions, reset values and states for the
 serial bit-rate, status and data block.
 Assumes a 32-bit AXI4-Lite master and one 50 MHz bus clock.
*/
// Overview of operation
// - prescaler divides bus clock by field plus one
// - divider applies two to the field-plus-one power
// - bit-rate register readable and writable at any time
// - unused status bits read zero, writes ignored
// - receive-full sets when a byte is received
// - receive-full clears: status read, then data read
// - transmit-empty clears: status read, then data write
// - data write dropped without prior armed status read
// - transmit interrupt while empty and enabled
// - idle shifter takes new byte within two cycles
// - queued byte moves to shifter after each shift
// - mode fault on select low as master input
// - mode fault clears: status read, then control write
// - data reads receive buffer, writes transmit buffer
// - master transfer starts when a byte is queued
// - unread receive buffer keeps old byte silently
package spi_pkg;

   localparam int unsigned CLK_HZ = 50_000_000;

   localparam logic [7:0] OFS_BIT_RATE = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_DATA     = 8'h08;
   localparam logic [7:0] OFS_CONTROL  = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

   localparam int unsigned PRE_LSB = 4;
   localparam int unsigned DIV_LSB = 0;
   localparam int unsigned ST_RFF  = 7;
   localparam int unsigned ST_TEF  = 5;
   localparam int unsigned ST_MFF  = 4;
   localparam int unsigned CTL_SOE = 1;
   localparam int unsigned CTL_FDE = 2;
   localparam int unsigned CTL_MST = 4;
   localparam int unsigned CTL_TIE = 5;
   localparam int unsigned IRQ_RX  = 0;
   localparam int unsigned IRQ_TX  = 1;
   localparam int unsigned IRQ_MF  = 2;

   localparam logic [7:0] BIT_RATE_RST = 8'h00;
   localparam logic [7:0] CONTROL_RST  = 8'h00;
   localparam logic [7:0] DATA_RST     = 8'h00;
   localparam logic [2:0] IRQ_RST      = 3'h0;
   localparam logic [2:0] LAST_BIT     = 3'h7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {
      ST_IDLE  = 1'b0,
      ST_SHIFT = 1'b1
   } xfer_state_e;

endpackage : spi_pkg

// File: spi_baud_status_data.sv
/*
 spi_baud_status_data: AXI4-Lite register slave, bit-rate generator,
 status flags with read-then-access clearing, double-buffered data
 path and a simple master shifter (sample on rising sclk, msb first).
 Assumes miso_i and ss_n_i are asynchronous pins; the bus master
 keeps AXI4-Lite handshake rules.
*/
`timescale 1ns/1ps
module spi_baud_status_data (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   output logic             sclk_o,
   output logic             mosi_o,
   input  wire logic        miso_i,
   input  wire logic        ss_n_i,
   output logic             ss_n_o,
   output logic             ss_oe_o,
   output logic             irq_o,
   output logic             tx_irq_o
);

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == spi_pkg::OFS_BIT_RATE) || (a == spi_pkg::OFS_STATUS)
             || (a == spi_pkg::OFS_DATA) || (a == spi_pkg::OFS_CONTROL)
             || (a == spi_pkg::OFS_IRQ_STAT)
             || (a == spi_pkg::OFS_IRQ_MASK);
   endfunction : addr_ok

   // divider top count: 2 << sel minus one; wraps to ff for 256
   function automatic logic [7:0] div_top(input logic [2:0] sel);
      div_top = (8'h02 << sel) - 8'h01;
   endfunction : div_top

   logic [7:0]  bit_rate_config;
   logic [7:0]  control_one;
   logic [7:0]  rx_buf;
   logic [7:0]  tx_buf;
   logic [7:0]  shifter;
   logic [2:0]  irq_stat;
   logic [2:0]  irq_mask;
   logic        tx_full;
   logic        receive_full_flag;
   logic        mode_fault_flag;
   logic        rff_armed;
   logic        tef_armed;
   logic        mff_armed;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        aw_have;
   logic        w_have;
   logic [2:0]  pre_cnt;
   logic [7:0]  div_cnt;
   logic [2:0]  bit_cnt;
   logic        rx_bit;
   logic        miso_s1;
   logic        miso_s2;
   logic        ss_s1;
   logic        ss_s2;
   logic        ss_prev;
   spi_pkg::xfer_state_e state;

   logic        transmit_empty_flag;
   logic [2:0]  prescale_select;
   logic [2:0]  rate_divide_select;
   logic        master_select;
   logic        fault_detect_enable;
   logic        select_output_enable;
   logic        transmit_irq_enable;
   logic        wr_fire;
   logic        wr_strb0;
   logic        rd_fire;
   logic        rd_status;
   logic        rd_data;
   logic        wr_data;
   logic        data_taken;
   logic        rff_clear;
   logic        mff_clear;
   logic        load_shift;
   logic        pre_tick;
   logic        sample_evt;
   logic        end_evt;
   logic        xfer_done;
   logic        rff_set;
   logic        mff_set;
   logic [7:0]  rx_byte;
   logic [7:0]  status_val;
   logic [2:0]  irq_events;

   localparam logic [2:0] IRQ_RST_V = spi_pkg::IRQ_RST;

   assign transmit_empty_flag  = ~tx_full;
   assign prescale_select      = bit_rate_config[spi_pkg::PRE_LSB +: 3];
   assign rate_divide_select   = bit_rate_config[spi_pkg::DIV_LSB +: 3];
   assign master_select        = control_one[spi_pkg::CTL_MST];
   assign fault_detect_enable  = control_one[spi_pkg::CTL_FDE];
   assign select_output_enable = control_one[spi_pkg::CTL_SOE];
   assign transmit_irq_enable  = control_one[spi_pkg::CTL_TIE];

   // ---------------- AXI4-Lite write channel
   assign wr_fire  = aw_have & w_have & ~s_axi_bvalid_o;
   assign wr_strb0 = wr_fire & w_strb[0];

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_awready_o <= 1'b0;
         aw_have         <= 1'b0;
         aw_addr         <= 8'h00;
      end
      else if (s_axi_awvalid_i && s_axi_awready_o)
      begin
         s_axi_awready_o <= 1'b0;
         aw_have         <= 1'b1;
         aw_addr         <= s_axi_awaddr_i;
      end
      else if (wr_fire)
         aw_have <= 1'b0;
      else if (!aw_have && !s_axi_bvalid_o)
         s_axi_awready_o <= 1'b1;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_wready_o <= 1'b0;
         w_have         <= 1'b0;
         w_data         <= 32'h0000_0000;
         w_strb         <= 4'h0;
      end
      else if (s_axi_wvalid_i && s_axi_wready_o)
      begin
         s_axi_wready_o <= 1'b0;
         w_have         <= 1'b1;
         w_data         <= s_axi_wdata_i;
         w_strb         <= s_axi_wstrb_i;
      end
      else if (wr_fire)
         w_have <= 1'b0;
      else if (!w_have && !s_axi_bvalid_o)
         s_axi_wready_o <= 1'b1;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= spi_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= addr_ok(aw_addr) ? spi_pkg::RESP_OKAY
                                            : spi_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready_i)
         s_axi_bvalid_o <= 1'b0;
   end

   // ---------------- AXI4-Lite read channel
   assign rd_fire   = s_axi_arvalid_i & s_axi_arready_o;
   assign rd_status = rd_fire & (s_axi_araddr_i == spi_pkg::OFS_STATUS);
   assign rd_data   = rd_fire & (s_axi_araddr_i == spi_pkg::OFS_DATA);

   // unused status bits stay zero by construction
   always_comb
   begin
      status_val                 = 8'h00;
      status_val[spi_pkg::ST_RFF] = receive_full_flag;
      status_val[spi_pkg::ST_TEF] = transmit_empty_flag;
      status_val[spi_pkg::ST_MFF] = mode_fault_flag;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= spi_pkg::RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rresp_o   <= addr_ok(s_axi_araddr_i) ? spi_pkg::RESP_OKAY
                                                    : spi_pkg::RESP_SLVERR;
         case (s_axi_araddr_i)
            spi_pkg::OFS_BIT_RATE: s_axi_rdata_o <= {24'h0, bit_rate_config};
            spi_pkg::OFS_STATUS:   s_axi_rdata_o <= {24'h0, status_val};
            spi_pkg::OFS_DATA:     s_axi_rdata_o <= {24'h0, rx_buf};
            spi_pkg::OFS_CONTROL:  s_axi_rdata_o <= {24'h0, control_one};
            spi_pkg::OFS_IRQ_STAT: s_axi_rdata_o <= {29'h0, irq_stat};
            spi_pkg::OFS_IRQ_MASK: s_axi_rdata_o <= {29'h0, irq_mask};
            default:               s_axi_rdata_o <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
         s_axi_rvalid_o <= 1'b0;
      else if (!s_axi_rvalid_o)
         s_axi_arready_o <= 1'b1;
   end

   // ---------------- configuration registers
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         bit_rate_config <= spi_pkg::BIT_RATE_RST;
      else if (wr_strb0 && aw_addr == spi_pkg::OFS_BIT_RATE)
         bit_rate_config <= w_data[7:0] & 8'h77;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         control_one <= spi_pkg::CONTROL_RST;
      else if (wr_strb0 && aw_addr == spi_pkg::OFS_CONTROL)
         control_one <= w_data[7:0] & 8'h36;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         irq_mask <= IRQ_RST_V;
      else if (wr_strb0 && aw_addr == spi_pkg::OFS_IRQ_MASK)
         irq_mask <= w_data[2:0];
   end

   // ---------------- flag arming by status reads
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         rff_armed <= 1'b0;
         tef_armed <= 1'b0;
         mff_armed <= 1'b0;
      end
      else
      begin
         if (rd_status)
            rff_armed <= receive_full_flag;
         else if (rd_data)
            rff_armed <= 1'b0;
         if (rd_status)
            tef_armed <= transmit_empty_flag;
         else if (wr_data)
            tef_armed <= 1'b0;
         if (rd_status)
            mff_armed <= mode_fault_flag;
         else if (mff_clear)
            mff_armed <= 1'b0;
      end
   end

   assign wr_data    = wr_fire && aw_addr == spi_pkg::OFS_DATA;
   assign data_taken = wr_data & w_strb[0] & tef_armed;
   assign rff_clear  = rd_data & rff_armed;
   assign mff_clear  = wr_fire && aw_addr == spi_pkg::OFS_CONTROL
                       && mff_armed;

   // ---------------- transmit buffer
   // tx_full low is the transmit-empty flag; a taken write finds it empty
   // unless a status read accepted in the same cycle as the previous taken
   // write re-armed tef_armed; then load and write can collide, and load wins
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         tx_full <= 1'b0;
         tx_buf  <= spi_pkg::DATA_RST;
      end
      else if (load_shift)
         tx_full <= 1'b0;
      else if (data_taken)
      begin
         tx_full <= 1'b1;
         tx_buf  <= w_data[7:0];
      end
   end

   // ---------------- bit-rate generator
   assign pre_tick   = (pre_cnt == prescale_select);
   assign sample_evt = pre_tick
                       && div_cnt == (div_top(rate_divide_select) >> 1);
   assign end_evt    = pre_tick
                       && div_cnt == div_top(rate_divide_select);
   assign xfer_done  = end_evt && bit_cnt == spi_pkg::LAST_BIT;

   // counters restart per transfer so every bit has full length
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i || state != spi_pkg::ST_SHIFT)
      begin
         pre_cnt <= 3'h0;
         div_cnt <= 8'h00;
      end
      else if (pre_tick)
      begin
         pre_cnt <= 3'h0;
         div_cnt <= end_evt ? 8'h00 : div_cnt + 8'h01;
      end
      else
         pre_cnt <= pre_cnt + 3'h1;
   end

   // ---------------- pin synchronisers
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         miso_s1 <= 1'b0;
         miso_s2 <= 1'b0;
         ss_s1   <= 1'b1;
         ss_s2   <= 1'b1;
         ss_prev <= 1'b1;
      end
      else
      begin
         miso_s1 <= miso_i;
         miso_s2 <= miso_s1;
         ss_s1   <= ss_n_i;
         ss_s2   <= ss_s1;
         ss_prev <= ss_s2;
      end
   end

   // ---------------- shifter
   assign load_shift = state == spi_pkg::ST_IDLE && tx_full
                       && master_select;
   assign rx_byte    = {shifter[6:0], rx_bit};

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         state   <= spi_pkg::ST_IDLE;
         shifter <= 8'h00;
         bit_cnt <= 3'h0;
         rx_bit  <= 1'b0;
         sclk_o  <= 1'b0;
         mosi_o  <= 1'b0;
      end
      else
      begin
         case (state)
            spi_pkg::ST_IDLE:
            begin
               sclk_o <= 1'b0;
               if (load_shift)
               begin
                  state   <= spi_pkg::ST_SHIFT;
                  shifter <= tx_buf;
                  mosi_o  <= tx_buf[7];
                  bit_cnt <= 3'h0;
               end
            end
            spi_pkg::ST_SHIFT:
            begin
               if (sample_evt)
               begin
                  sclk_o <= 1'b1;
                  rx_bit <= miso_s2;
               end
               if (end_evt)
               begin
                  sclk_o  <= 1'b0;
                  shifter <= rx_byte;
                  mosi_o  <= shifter[6];
                  bit_cnt <= bit_cnt + 3'h1;
                  if (xfer_done)
                     state <= spi_pkg::ST_IDLE;
               end
            end
            default:
               state <= spi_pkg::ST_IDLE;
         endcase
      end
   end

   // ---------------- receive buffer and flag
   // a clear in the same cycle as a completion lets the new byte in
   assign rff_set = xfer_done;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         rx_buf            <= spi_pkg::DATA_RST;
         receive_full_flag <= 1'b0;
      end
      else
      begin
         if (rff_set && (!receive_full_flag || rff_clear))
            rx_buf <= rx_byte;
         receive_full_flag <= rff_set | (receive_full_flag & ~rff_clear);
      end
   end

   // ---------------- mode fault
   assign mff_set = master_select & fault_detect_enable
                    & ~select_output_enable
                    & ss_prev & ~ss_s2;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         mode_fault_flag <= 1'b0;
      else
         mode_fault_flag <= mff_set | (mode_fault_flag & ~mff_clear);
   end

   // ---------------- interrupts
   assign irq_events = {mff_set, load_shift, rff_set};

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         irq_stat <= IRQ_RST_V;
      else if (wr_strb0 && aw_addr == spi_pkg::OFS_IRQ_STAT)
         irq_stat <= irq_events | (irq_stat & ~w_data[2:0]);
      else
         irq_stat <= irq_events | irq_stat;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         irq_o    <= 1'b0;
         tx_irq_o <= 1'b0;
         ss_n_o   <= 1'b1;
         ss_oe_o  <= 1'b0;
      end
      else
      begin
         irq_o    <= |(irq_stat & irq_mask);
         tx_irq_o <= transmit_empty_flag & transmit_irq_enable;
         ss_n_o   <= ~(state == spi_pkg::ST_SHIFT);
         ss_oe_o  <= master_select & fault_detect_enable
                     & select_output_enable;
      end
   end

endmodule : spi_baud_status_data

// File: spi_bsd_checker_assertions.sv
/*
 checker: bus handshakes, frame and bit timing.
 assumes bit rate is rewritten only between frames.
*/
`timescale 1ns/1ps
module spi_bsd_checker (
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire logic [7:0]  s_axi_awaddr_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0]  s_axi_wstrb_i,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic        s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic        sclk_o,
   input wire logic        mosi_o,
   input wire logic        ss_n_o
);
   logic [7:0]  waddr;
   logic [8:0]  wbyte;
   logic [7:0]  rate_cfg;
   logic [15:0] hi_cnt;
   logic [3:0]  bit_cnt;
   logic [15:0] half;
   // half bit length mirrors the prescale then divide cascade
   assign half = ({13'h0, rate_cfg[6:4]} + 16'h1) << rate_cfg[2:0];
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge clk_sys_i)
   begin
      if (s_axi_awvalid_i && s_axi_awready_o) waddr <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o)
         wbyte <= {s_axi_wstrb_i[0], s_axi_wdata_i[7:0]};
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i) rate_cfg <= 8'h00;
      else if ($rose(s_axi_bvalid_o) && waddr == spi_pkg::OFS_BIT_RATE
               && wbyte[8]) rate_cfg <= wbyte[7:0];
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i || !sclk_o) hi_cnt <= 16'h0;
      else hi_cnt <= hi_cnt + 16'h1;
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i || ss_n_o) bit_cnt <= 4'h0;
      else if ($rose(sclk_o)) bit_cnt <= bit_cnt + 4'h1;
   end
   property p_rdata_byte;
      s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0;
   endproperty
   a_rdata_byte: assert property (p_rdata_byte)
      else $error("read data above bit 7 not zero");
   property p_bhold;
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
   endproperty
   a_bhold: assert property (p_bhold)
      else $error("write response dropped early");
   property p_rhold;
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
   endproperty
   a_rhold: assert property (p_rhold)
      else $error("read data dropped early");
   property p_wr_refuse;
      s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
   endproperty
   a_wr_refuse: assert property (p_wr_refuse)
      else $error("write accepted while response pending");
   property p_rd_refuse;
      s_axi_rvalid_o |-> !s_axi_arready_o;
   endproperty
   a_rd_refuse: assert property (p_rd_refuse)
      else $error("read accepted while data pending");
   property p_sclk_frame;
      ss_n_o |-> !sclk_o;
   endproperty
   a_sclk_frame: assert property (p_sclk_frame)
      else $error("serial clock outside frame");
   property p_mosi_hold;
      sclk_o |-> $stable(mosi_o);
   endproperty
   a_mosi_hold: assert property (p_mosi_hold)
      else $error("data out changed while clock high");
   property p_half_bit;
      $fell(sclk_o) |-> hi_cnt == half;
   endproperty
   a_half_bit: assert property (p_half_bit)
      else $error("serial clock high time wrong");
   property p_frame_bits;
      $rose(ss_n_o) |-> bit_cnt == 4'h8;
   endproperty
   a_frame_bits: assert property (p_frame_bits)
      else $error("frame did not carry eight bits");
   property p_slverr;
      $rose(s_axi_bvalid_o) && waddr > spi_pkg::OFS_IRQ_MASK
         |-> s_axi_bresp_o == spi_pkg::RESP_SLVERR;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("unmapped write not refused");
endmodule : spi_bsd_checker
bind spi_baud_status_data spi_bsd_checker u_chk (.clk_sys_i, .rst_n_i,
   .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
   .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
   .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arready_o, .s_axi_rdata_o,
   .s_axi_rvalid_o, .s_axi_rready_i, .sclk_o, .mosi_o, .ss_n_o);

// File: spi_slave_model.sv
/*
 far-side slave: msb first out on miso, captures mosi.
 assumes clock idles low, sample rising, shift falling.
*/
`timescale 1ns/1ps
module spi_slave_model (
   input  wire logic       sclk_i,
   input  wire logic       mosi_i,
   input  wire logic       ss_n_i,
   input  wire logic [7:0] tx_byte_i,
   output logic            miso_o,
   output logic [7:0]      rx_byte_o
);
   logic [7:0] sh;
   logic [7:0] rx;
   initial
   begin
      miso_o = 1'b0;
      rx_byte_o = 8'h00;
   end
   always @(negedge ss_n_i)
   begin
      sh = tx_byte_i;
      miso_o = tx_byte_i[7];
   end
   always @(posedge sclk_i) if (!ss_n_i) rx = {rx[6:0], mosi_i};
   always @(negedge sclk_i)
   begin
      if (!ss_n_i) sh = {sh[6:0], 1'b0};
      if (!ss_n_i) miso_o = sh[7];
   end
   // released line: no pull, so show the inverse rather than hold
   always @(posedge ss_n_i)
   begin
      rx_byte_o = rx;
      miso_o = ~miso_o;
   end
endmodule : spi_slave_model

// File: tb.sv
/*
 bench with a serial slave model.
 assumes bus answers in 50 cycles, frames end in 40k.
*/
`timescale 1ns/1ps
module tb;
   typedef struct {logic [31:0] exp; logic [31:0] msk; logic [1:0] rsp;} note_s;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [7:0]  s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
   logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
   logic [31:0] s_axi_wdata_i = 32'h0;
   logic [3:0]  s_axi_wstrb_i = 4'hf;
   logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
   logic        s_axi_rready_i = 1'b0, ss_n_i = 1'b1, miso_i;
   logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic        s_axi_arready_o, s_axi_rvalid_o, sclk_o, mosi_o;
   logic        ss_n_o, ss_oe_o, irq_o, tx_irq_o;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic [31:0] s_axi_rdata_o;
   logic [7:0]  slv_tx = 8'h0, slv_rx, cfg, a, b, s1, s2;
   localparam logic [7:0] BR = spi_pkg::OFS_BIT_RATE, ST = spi_pkg::OFS_STATUS,
      DT = spi_pkg::OFS_DATA, CT = spi_pkg::OFS_CONTROL,
      IS = spi_pkg::OFS_IRQ_STAT, IM = spi_pkg::OFS_IRQ_MASK;
   note_s       rq[$];
   logic [1:0]  bq[$];
   int          miscompares = 0, comparisons = 0, frames = 0, f0, h;
   always #10 clk_sys_i = ~clk_sys_i;
   always @(negedge ss_n_o) frames++;
   spi_baud_status_data dut (.clk_sys_i, .rst_n_i, .s_axi_awaddr_i,
      .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
      .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
      .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
      .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
      .sclk_o, .mosi_o, .miso_i, .ss_n_i, .ss_n_o, .ss_oe_o, .irq_o,
      .tx_irq_o);
   spi_slave_model u_slave (.sclk_i(sclk_o), .mosi_i(mosi_o), .ss_n_i(ss_n_o),
      .tx_byte_i(slv_tx), .miso_o(miso_i), .rx_byte_o(slv_rx));
   task automatic check(input string nm, input logic [33:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   always @(posedge clk_sys_i)
   begin : mon
      note_s n;
      if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i)
      begin
         n = rq.pop_front();
         check("read", {s_axi_rresp_o, s_axi_rdata_o & n.msk}, {n.rsp, n.exp});
      end
      if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i)
         check("bresp", {32'h0, s_axi_bresp_o}, {32'h0, bq.pop_front()});
   end
   task automatic wr(input logic [7:0] ad, d, input logic [1:0] r = 2'h0);
      int n;
      bq.push_back(r);
      @(posedge clk_sys_i);
      s_axi_awaddr_i <= ad;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wdata_i <= {24'h0, d};
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         n++;
         if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      end
      while (s_axi_bvalid_o !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
      s_axi_bready_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] ad, e, m = 8'hff,
                     input logic [1:0] r = 2'h0);
      int n;
      rq.push_back('{{24'h0, e & m}, {24'hffffff, m}, r});
      @(posedge clk_sys_i);
      s_axi_araddr_i <= ad;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         n++;
         if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      end
      while (s_axi_rvalid_o !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
      s_axi_rready_i <= 1'b0;
   endtask : rd
   task automatic wait_frame;
      int n;
      n = 0;
      while (ss_n_o !== 1'b0 && n < 40000)
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (ss_n_o !== 1'b1 && n < 40000)
      begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n >= 40000) miscompares++;
   endtask : wait_frame
   task automatic settle;
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask : settle
   initial
   begin
      void'($urandom(32'h7034));
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(BR, 8'h00);
      rd(ST, 8'h20);
      rd(DT, 8'h00);
      rd(IM, 8'h00);
      rd(8'h18, 8'h00, 8'hff, spi_pkg::RESP_SLVERR);
      wr(8'h18, 8'hff, spi_pkg::RESP_SLVERR);
      wr(ST, 8'hff);
      rd(ST, 8'h20);
      cfg = 8'($urandom);
      wr(BR, cfg);
      rd(BR, cfg & 8'h77);
      wr(CT, 8'h30);
      settle();
      check("tx_irq", {33'h0, tx_irq_o}, 34'h1);
      // each divide code, then each prescale over divide four
      for (int j = 0; j < 16; j++)
      begin
         cfg = (j < 8) ? 8'(j) : 8'(((j - 8) << 4) | 1);
         h = (int'(cfg[6:4]) + 1) << cfg[2:0];
         a = 8'($urandom);
         s1 = 8'($urandom);
         slv_tx <= s1;
         wr(BR, cfg);
         rd(BR, cfg);
         rd(ST, 8'h20);
         wr(DT, a);
         wait_frame();
         check("mosi byte", {26'h0, slv_rx}, {26'h0, a});
         rd(ST, 8'ha0);
         // the miso synchroniser cannot follow the fastest rates
         rd(DT, s1, (h >= 4) ? 8'hff : 8'h00);
         rd(ST, 8'h20);
      end
      wr(IM, 8'h07);
      rd(IS, 8'h03);
      settle();
      check("irq on", {33'h0, irq_o}, 34'h1);
      wr(IM, 8'h00);
      settle();
      check("irq masked", {33'h0, irq_o}, 34'h0);
      wr(IS, 8'h07);
      rd(IS, 8'h00);
      wr(BR, 8'h12);
      {a, b, s1, s2} = $urandom;
      slv_tx <= s1;
      f0 = frames;
      rd(ST, 8'h20);
      wr(DT, a);
      rd(ST, 8'h20);
      wr(DT, b);
      rd(ST, 8'h00);
      check("tx_irq off", {33'h0, tx_irq_o}, 34'h0);
      wr(DT, 8'(~b));
      wait_frame();
      slv_tx <= s2;
      check("first byte", {26'h0, slv_rx}, {26'h0, a});
      wait_frame();
      check("second byte", {26'h0, slv_rx}, {26'h0, b});
      repeat (300) @(posedge clk_sys_i);
      check("frames", 34'(frames - f0), 34'h2);
      rd(ST, 8'ha0);
      rd(DT, s1);
      rd(ST, 8'h20);
      for (int k = 0; k < 3; k++)
      begin
         cfg = (k == 0) ? 8'h34 : ((k == 1) ? 8'h36 : 8'h30);
         wr(CT, cfg);
         rd(ST, 8'h20);
         ss_n_i <= 1'b0;
         repeat (6) @(posedge clk_sys_i);
         ss_n_i <= 1'b1;
         settle();
         check("ss_oe", {33'h0, ss_oe_o}, 34'(k == 1));
         wr(CT, cfg);
         rd(ST, (k == 0) ? 8'h30 : 8'h20);
         wr(CT, cfg);
         rd(ST, 8'h20);
      end
      end_of_test();
   end
   initial
   begin
      #1_900_000;
      miscompares++;
      end_of_test();
   end
endmodule : tb
